/* bss_pkg.sv */
// Behaviour
// R1: one 32-bit config word at 0x90, resets zero
// R2: comparator 0-3 polarity bits at 28:25
// R3: active level is polarity bit xor global
// R4: pin 2-0 polarity bits at 18:16
// R5: bits 21:19 pick comparator for clear
// R6: bits 15:10 gate comparators 6 to 1
// R7: config writes only when protection level 00
// R8: software writes reserved bits as zero
// R9: bit9 comparator0, bit8 filter, bit7 comparator7 gates
// R10: bits 2:0 gate pins; 6:3 reserved
// R11: request is OR of enabled conditioned sources
package bss_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned NUM_CMP = 8;
  localparam int unsigned NUM_PIN = 3;
  localparam int unsigned SEL_W   = 3;
  localparam int unsigned PLVL_W  = 2;
  localparam int unsigned NUM_SRC = NUM_CMP + 1 + NUM_PIN;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CFG    = 8'h90;

  localparam logic [DATA_W-1:0] CFG_RESET  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // config word fields
  // ----------------------------------------------------------------
  localparam int unsigned POS_CMP_INV  = 25;
  localparam int unsigned POS_OC_SEL   = 19;
  localparam int unsigned POS_PIN_INV  = 16;
  localparam int unsigned POS_CMP1_EN  = 10;
  localparam int unsigned POS_CMP0_EN  = 9;
  localparam int unsigned POS_FILT_EN  = 8;
  localparam int unsigned POS_CMP7_EN  = 7;
  localparam int unsigned POS_PIN_EN   = 0;
  localparam int unsigned NUM_CMP_INV  = 4;
  localparam int unsigned NUM_MID_CMP  = 6;

  // ----------------------------------------------------------------
  // own control and status words
  // ----------------------------------------------------------------
  localparam int unsigned POS_PLVL     = 0;
  localparam int unsigned POS_GPOL     = 2;
  localparam int unsigned POS_ST_REQ   = 0;
  localparam int unsigned POS_ST_OCCLR = 1;
  localparam int unsigned POS_ST_BLOCK = 2;
  localparam int unsigned POS_ST_SRC   = 8;
  localparam logic [PLVL_W-1:0] PLVL_OPEN = 2'h0;
  localparam logic [3:0] STRB_FULL = 4'hF;

  typedef struct packed {
    logic [NUM_CMP_INV-1:0] cmp_inv;
    logic [SEL_W-1:0]       oc_sel;
    logic [NUM_PIN-1:0]     pin_inv;
    logic [NUM_CMP-1:0]     cmp_gate;
    logic                   filter_gate;
    logic [NUM_PIN-1:0]     pin_gate;
  } bss_cfg_s;

  typedef struct packed {
    logic [NUM_CMP-1:0] comparator_outputs;
    logic               filter_block;
    logic [NUM_PIN-1:0] break_pins;
  } bss_src_s;

endpackage

/* bss_src_cond.sv */
module bss_src_cond #(
  parameter int unsigned N = 12
) (
  input  wire logic [N-1:0] raw_i,
  input  wire logic [N-1:0] invert_i,
  input  wire logic [N-1:0] gate_i,
  input  wire logic         global_pol_i,
  output logic      [N-1:0] asserted_o,
  output logic              any_o
);

  if (N < 1) begin : g_chk
    $error("bss_src_cond needs at least one source");
  end

  // ------------------------------------------------------------------
  // per-source conditioning
  // ------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_src
    // active high when the polarity bit and global polarity differ
    assign asserted_o[i] = gate_i[i] & ~(raw_i[i] ^ (invert_i[i] ^ global_pol_i)); // R3 R11
  end

  assign any_o = |asserted_o; // R11

endmodule

/* bss_top.sv */
module bss_top #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  // apb slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [ADDR_W-1:0]        paddr_i,
  input  wire logic [bss_pkg::DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]               pstrb_i,
  output logic      [bss_pkg::DATA_W-1:0] prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // break sources
  input  wire bss_pkg::bss_src_s        sources_i,
  // results
  output logic                          break1_request_o,
  output logic                          oc_reference_clear_input_o,
  output bss_pkg::bss_cfg_s             cfg_o
);
  import bss_pkg::*;

  if (ADDR_W < 8) begin : g_chk
    $error("bss_top needs at least 8 address bits");
  end

  // ------------------------------------------------------------------
  // layout checks: carriers, word map and status map must agree
  // ------------------------------------------------------------------
  if ($bits(bss_src_s) != NUM_SRC) begin : g_chk_src
    $error("source carrier width differs from the source count");
  end
  if ($bits(bss_cfg_s) != NUM_SRC + NUM_CMP_INV + SEL_W + NUM_PIN) begin : g_chk_cfg
    $error("config carrier width differs from the field sizes");
  end
  if ((1 << SEL_W) != NUM_CMP) begin : g_chk_sel
    $error("clear select must reach every comparator");
  end
  if (NUM_MID_CMP != NUM_CMP - 2) begin : g_chk_mid
    $error("only the first and last comparator gates sit apart");
  end
  if (NUM_CMP_INV > NUM_CMP) begin : g_chk_inv
    $error("more polarity bits than comparators");
  end
  if (POS_CMP_INV + NUM_CMP_INV > DATA_W) begin : g_chk_top
    $error("comparator polarity field leaves the word");
  end
  if (POS_CMP1_EN + NUM_MID_CMP > POS_PIN_INV) begin : g_chk_gate
    $error("comparator gate field runs into pin polarity");
  end
  if (POS_ST_SRC + NUM_SRC > DATA_W) begin : g_chk_stat
    $error("status source vector leaves the word");
  end
  if (POS_GPOL < POS_PLVL + PLVL_W) begin : g_chk_ctrl
    $error("global polarity overlaps the protection level");
  end
  if (DATA_W != 8 * $bits(STRB_FULL)) begin : g_chk_strb
    $error("strobe lanes do not cover the data word");
  end

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSS_REG_CTRL   = 2'b00,
    BSS_REG_STATUS = 2'b01,
    BSS_REG_CFG    = 2'b10,
    BSS_REG_NONE   = 2'b11
  } bss_reg_e;

  function automatic bss_reg_e decode(input logic [ADDR_W-1:0] addr);
    bss_reg_e r;
    r = BSS_REG_NONE;
    if ((addr >> $bits(OFS_CFG)) == '0) begin
      unique case (addr[7:0])
        OFS_CTRL:   r = BSS_REG_CTRL;
        OFS_STATUS: r = BSS_REG_STATUS;
        OFS_CFG:    r = BSS_REG_CFG;
        default:    r = BSS_REG_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] cfg_to_word(input bss_cfg_s c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[POS_CMP_INV +: NUM_CMP_INV] = c.cmp_inv; // R2
    w[POS_OC_SEL +: SEL_W]        = c.oc_sel; // R5
    w[POS_PIN_INV +: NUM_PIN]     = c.pin_inv; // R4
    w[POS_CMP1_EN +: NUM_MID_CMP] = c.cmp_gate[NUM_MID_CMP:1]; // R6
    w[POS_CMP0_EN]                = c.cmp_gate[0]; // R9
    w[POS_FILT_EN]                = c.filter_gate; // R9
    w[POS_CMP7_EN]                = c.cmp_gate[NUM_CMP-1]; // R9
    w[POS_PIN_EN +: NUM_PIN]      = c.pin_gate; // R10
    return w;
  endfunction

  function automatic bss_cfg_s word_to_cfg(input logic [DATA_W-1:0] w);
    bss_cfg_s c;
    c                          = '0;
    c.cmp_inv                  = w[POS_CMP_INV +: NUM_CMP_INV];
    c.oc_sel                   = w[POS_OC_SEL +: SEL_W];
    c.pin_inv                  = w[POS_PIN_INV +: NUM_PIN];
    c.cmp_gate[NUM_MID_CMP:1]  = w[POS_CMP1_EN +: NUM_MID_CMP];
    c.cmp_gate[0]              = w[POS_CMP0_EN];
    c.filter_gate              = w[POS_FILT_EN];
    c.cmp_gate[NUM_CMP-1]      = w[POS_CMP7_EN];
    c.pin_gate                 = w[POS_PIN_EN +: NUM_PIN];
    return c;
  endfunction

  localparam bss_cfg_s CFG_RESET_FIELDS = word_to_cfg(CFG_RESET);

  // ------------------------------------------------------------------
  // bus phases
  // ------------------------------------------------------------------
  bss_reg_e reg_sel;
  logic     setup_ph;
  logic     access_ph;
  logic     full_word;
  logic     bad_access;
  logic     wr_ok;

  assign reg_sel    = decode(paddr_i);
  assign setup_ph   = psel_i & ~penable_i;
  assign access_ph  = psel_i & penable_i;
  // partial-lane writes are refused outright rather than merged
  assign full_word  = ~pwrite_i | (pstrb_i == STRB_FULL); // R1
  assign bad_access = (reg_sel == BSS_REG_NONE) | ~full_word;
  assign wr_ok      = access_ph & pwrite_i & ~bad_access;

  assign pready_o   = access_ph;
  assign pslverr_o  = access_ph & bad_access;

  // ------------------------------------------------------------------
  // control word: protection level and global polarity
  // ------------------------------------------------------------------
  logic [PLVL_W-1:0] protection_level_q;
  logic              break1_global_polarity_q;
  logic              cfg_open;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      protection_level_q       <= CTRL_RESET[POS_PLVL +: PLVL_W];
      break1_global_polarity_q <= CTRL_RESET[POS_GPOL];
    end else if (wr_ok && reg_sel == BSS_REG_CTRL) begin
      protection_level_q       <= pwdata_i[POS_PLVL +: PLVL_W];
      break1_global_polarity_q <= pwdata_i[POS_GPOL];
    end
  end

  assign cfg_open = (protection_level_q == PLVL_OPEN); // R7

  // ------------------------------------------------------------------
  // break 1 source configuration word
  // ------------------------------------------------------------------
  bss_cfg_s cfg_q;
  logic     cfg_wr;

  assign cfg_wr = wr_ok & (reg_sel == BSS_REG_CFG);

  // reserved bits are dropped on write and read back as zero
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= CFG_RESET_FIELDS; // R1
    end else if (cfg_wr && cfg_open) begin // R7
      cfg_q <= word_to_cfg(pwdata_i);
    end
  end

  assign cfg_o = cfg_q;

  // ------------------------------------------------------------------
  // locked-write sticky flag, cleared by writing one to it
  // ------------------------------------------------------------------
  logic blocked_q;
  logic blocked_set;
  logic blocked_clr;

  assign blocked_set = cfg_wr & ~cfg_open; // R7
  assign blocked_clr = wr_ok & (reg_sel == BSS_REG_STATUS) & pwdata_i[POS_ST_BLOCK];

  // a set in the clearing cycle wins so no refused write goes unseen
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      blocked_q <= 1'b0;
    end else if (blocked_set) begin
      blocked_q <= 1'b1;
    end else if (blocked_clr) begin
      blocked_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // source conditioning
  // ------------------------------------------------------------------
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] src_inv;
  logic [NUM_SRC-1:0] src_gate;
  logic [NUM_SRC-1:0] src_asserted;
  logic               src_any;

  assign src_raw  = sources_i;
  // comparators 4-7 and the filter block have no own polarity bit
  assign src_inv  = {{(NUM_CMP - NUM_CMP_INV){1'b0}}, cfg_q.cmp_inv, 1'b0,
                     cfg_q.pin_inv}; // R2 R4
  assign src_gate = {cfg_q.cmp_gate, cfg_q.filter_gate, cfg_q.pin_gate}; // R6 R9 R10

  bss_src_cond #(
    .N (NUM_SRC)
  ) u_cond (
    .raw_i        (src_raw),
    .invert_i     (src_inv),
    .gate_i       (src_gate),
    .global_pol_i (break1_global_polarity_q),
    .asserted_o   (src_asserted),
    .any_o        (src_any)
  );

  // ------------------------------------------------------------------
  // registered results
  // ------------------------------------------------------------------
  logic break1_request_q;
  logic oc_clear_q;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      break1_request_q <= 1'b0;
    end else begin
      break1_request_q <= src_any; // R11
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      oc_clear_q <= 1'b0;
    end else begin
      oc_clear_q <= sources_i.comparator_outputs[cfg_q.oc_sel]; // R5
    end
  end

  assign break1_request_o           = break1_request_q;
  assign oc_reference_clear_input_o = oc_clear_q;

  // ------------------------------------------------------------------
  // read data, captured in the setup cycle
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] prdata_q;

  always_comb begin
    rd_word = '0;
    unique case (reg_sel)
      BSS_REG_CTRL: begin
        rd_word[POS_PLVL +: PLVL_W] = protection_level_q;
        rd_word[POS_GPOL]           = break1_global_polarity_q;
      end
      BSS_REG_STATUS: begin
        rd_word[POS_ST_REQ]              = break1_request_q;
        rd_word[POS_ST_OCCLR]            = oc_clear_q;
        rd_word[POS_ST_BLOCK]            = blocked_q;
        rd_word[POS_ST_SRC +: NUM_SRC]   = src_asserted;
      end
      BSS_REG_CFG: begin
        rd_word = cfg_to_word(cfg_q);
      end
      BSS_REG_NONE: begin
        rd_word = '0;
      end
    endcase
  end

  // one-cycle answer: data is stable through the access phase
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata_q <= '0;
    end else if (setup_ph && !pwrite_i) begin
      prdata_q <= rd_word;
    end
  end

  assign prdata_o = prdata_q;

endmodule

/* bss_chk.sv */
module bss_chk #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic                clk_i,
  input wire logic                arst_n_i,
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pwrite_i,
  input wire logic [ADDR_W-1:0]   paddr_i,
  input wire logic [31:0]         pwdata_i,
  input wire logic [3:0]          pstrb_i,
  input wire logic [31:0]         prdata_o,
  input wire logic                pready_o,
  input wire logic                pslverr_o,
  input wire bss_pkg::bss_src_s   sources_i,
  input wire logic                break1_request_o,
  input wire logic                oc_reference_clear_input_o,
  input wire bss_pkg::bss_cfg_s   cfg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import bss_pkg::*;
  logic [1:0]  up_q;
  logic [2:0]  ctrl_q;
  logic        acc, a_ctl, a_cfg, hit, wr_cfg, ok, any_w, oc_w;
  logic [11:0] raw_w, inv_w, gate_w;
  logic [21:0] map_w;
  logic [31:0] rd_w;
  assign acc = psel_i && penable_i;
  assign ok = up_q == 2'h3;
  assign a_ctl = paddr_i == ADDR_W'(OFS_CTRL);
  assign a_cfg = paddr_i == ADDR_W'(OFS_CFG);
  assign hit = a_ctl || a_cfg || paddr_i == ADDR_W'(OFS_STATUS);
  assign wr_cfg = acc && pwrite_i && a_cfg && pstrb_i == STRB_FULL && ctrl_q[1:0] == PLVL_OPEN;
  assign raw_w = sources_i;
  assign gate_w = {cfg_o.cmp_gate, cfg_o.filter_gate, cfg_o.pin_gate};
  assign inv_w = {4'h0, cfg_o.cmp_inv, 1'b0, cfg_o.pin_inv};
  assign any_w = |(gate_w & ~(raw_w ^ inv_w ^ {12{ctrl_q[2]}}));
  assign oc_w = sources_i.comparator_outputs[cfg_o.oc_sel];
  assign map_w = {pwdata_i[28:25], pwdata_i[21:16], pwdata_i[7], pwdata_i[15:8], pwdata_i[2:0]};
  assign rd_w = {3'h0, cfg_o.cmp_inv, 3'h0, cfg_o.oc_sel, cfg_o.pin_inv, cfg_o.cmp_gate[6:0],
                 cfg_o.filter_gate, cfg_o.cmp_gate[7], 4'h0, cfg_o.pin_gate};
  // the design holds its own reset two edges longer, so wait three
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) up_q <= 2'h0;
    else if (!ok) up_q <= up_q + 2'h1;
  end
  // shadow of the control word: global polarity is not visible at the ports
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) ctrl_q <= 3'h0;
    else if (acc && pwrite_i && a_ctl && pstrb_i == STRB_FULL) ctrl_q <= pwdata_i[2:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_cfg_wr;
    ok && wr_cfg;
  endsequence
  chk_ready_zero_wait: assert property (acc |-> pready_o)
    else $error("pready low in access");
  chk_unmapped_err: assert property (acc && !hit |->
    pslverr_o && (pwrite_i || prdata_o == '0))
    else $error("unmapped access not refused");
  chk_strobe_err: assert property (acc && pwrite_i && pstrb_i != STRB_FULL |-> pslverr_o)
    else $error("partial write not refused");
  chk_cfg_write: assert property (s_cfg_wr |=> cfg_o == $past(map_w))
    else $error("config not stored");
  chk_cfg_locked: assert property (ok && !wr_cfg |=> $stable(cfg_o))
    else $error("config changed");
  chk_read_back: assert property (acc && !pwrite_i && a_cfg |-> prdata_o == rd_w)
    else $error("config read wrong");
  chk_request_or: assert property (ok |=> break1_request_o == $past(any_w))
    else $error("request wrong");
  chk_oc_select: assert property (ok ##1 1'b1 |-> oc_reference_clear_input_o == $past(oc_w))
    else $error("clear select wrong");
endmodule

bind bss_top bss_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
  .prdata_o, .pready_o, .pslverr_o, .sources_i, .break1_request_o,
  .oc_reference_clear_input_o, .cfg_o
);

/* bss_src_model.sv */
module bss_src_model (
  input  wire logic [11:0]  level_i,
  input  wire logic         clk_i,
  input  wire logic [1:0]   lag_i,
  output bss_pkg::bss_src_s src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import bss_pkg::*;
  logic [11:0] d1_q;
  logic [11:0] d2_q;
  // slow sources settle one or two cycles behind the requested level
  always_ff @(posedge clk_i) begin
    d1_q <= level_i;
    d2_q <= d1_q;
  end
  assign src_o = (lag_i == 2'h0) ? level_i : (lag_i == 2'h1) ? d1_q : d2_q;
endmodule

/* break1_source_select_tb.sv */
module break1_source_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bss_pkg::*;
  localparam logic [31:0] MASK = 32'h1E3F_FF87;
  localparam int LIMIT = 20000;
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, req, occ, er;
  logic [7:0]  paddr = 8'h00;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, w;
  logic [11:0] level = 12'h000;
  logic [1:0]  lag = 2'h0;
  bss_src_s    src;
  bss_cfg_s    cfg;
  int          seed, k, cyc, cfg_m, gpol_m, mismatches, n_tests;
  always #5 clk = ~clk;
  bss_src_model u_src (.level_i(level), .clk_i(clk), .lag_i(lag), .src_o(src));
  bss_top dut (
    .clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sources_i(src),
    .break1_request_o(req), .oc_reference_clear_input_o(occ), .cfg_o(cfg)
  );
  task automatic results();
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t bit %b exp %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wn, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wn;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, STRB_FULL);
  endtask
  task automatic rdw(input logic [7:0] a);
    apb(1'b0, a, 32'h0, STRB_FULL);
  endtask
  // request expected from gating, per-source inversion and global polarity
  function automatic logic exp_req(input logic [11:0] v);
    int g;
    exp_req = cfg_m[8] && v[3] == gpol_m[0];
    for (int j = 0; j < 8; j++) begin
      g = (j == 0) ? 9 : (j == 7) ? 7 : 9 + j;
      if (cfg_m[g] && v[4+j] == (gpol_m[0] ^ (j < 4 && cfg_m[25+j]))) exp_req = 1'b1;
      if (j < 3 && cfg_m[j] && v[j] == (gpol_m[0] ^ cfg_m[16+j])) exp_req = 1'b1;
    end
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      results();
    end
  end
  initial begin
    seed = 40274;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdw(OFS_CFG);
    cmp_word(rd, CFG_RESET);
    for (k = 0; k < 24; k++) begin
      gpol_m = $random(seed) & 1;
      w = $random(seed) & MASK;
      w[21:19] = k[2:0];
      // first passes: every source gated off
      if (k < 2) w[15:0] = 16'h0;
      wr(OFS_CTRL, {29'h0, gpol_m[0], 2'h0});
      wr(OFS_CFG, w);
      cfg_m = w;
      rdw(OFS_CFG);
      cmp_word(rd, w);
      level <= 12'($random(seed));
      lag <= 2'($random(seed));
      repeat (5) @(posedge clk);
      cmp_bit(req, exp_req(level));
      cmp_bit(occ, level[4 + k % 8]);
      rdw(OFS_STATUS);
      cmp_bit(rd[POS_ST_REQ], exp_req(level));
      cmp_bit(rd[POS_ST_OCCLR], level[4 + k % 8]);
    end
    for (k = 1; k < 4; k++) begin
      wr(OFS_CTRL, 32'(k));
      rdw(OFS_CTRL);
      cmp_word(rd, 32'(k));
      wr(OFS_CFG, ~w & MASK);
      rdw(OFS_CFG);
      cmp_word(rd, w);
    end
    wr(OFS_CTRL, 32'h0);
    rdw(OFS_STATUS);
    cmp_bit(rd[POS_ST_BLOCK], 1'b1);
    wr(OFS_STATUS, 32'(1 << POS_ST_BLOCK));
    rdw(OFS_STATUS);
    cmp_bit(rd[POS_ST_BLOCK], 1'b0);
    rdw(8'h94);
    cmp_word(rd, 32'h0);
    cmp_bit(er, 1'b1);
    apb(1'b1, OFS_CFG, ~w & MASK, 4'h3);
    cmp_bit(er, 1'b1);
    wr(8'h08, 32'hFFFF_FFFF);
    rdw(OFS_CFG);
    cmp_word(rd, w);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_bit(req, 1'b0);
    rdw(OFS_CFG);
    cmp_word(rd, CFG_RESET);
    results();
  end
endmodule
